// ===== pkg/i2c_status_pkg.sv
package i2c_status_pkg;
	// CPU address of the bus status register and its value after reset
	localparam logic [15:0] STATUS_ADDR  = 16'hffaa;
	localparam logic [7:0]  STATUS_RESET = 8'h00;

	// Status register bit positions
	localparam int MASTER_BIT = 7;
	localparam int ARB_BIT    = 6;
	localparam int EXT_BIT    = 5;
	localparam int MATCH_BIT  = 4;
	localparam int LOW_BITS   = 4;

	// Control register bit positions
	localparam int REL_BIT    = 6;
	localparam int ENABLE_BIT = 7;

	// Extension codes seen in the upper nibble of the address byte
	localparam logic [3:0] EXT_CODE_LOW  = 4'h0;
	localparam logic [3:0] EXT_CODE_HIGH = 4'hf;

	// Data bits per byte, the ninth clock carries the acknowledge
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] CNT_ONE   = 4'h1;

	// Events carried from the link domain by toggles
	localparam int EV_START = 0;
	localparam int EV_STOP  = 1;
	localparam int EV_ARB   = 2;
	localparam int EV_EXT   = 3;
	localparam int EV_MATCH = 4;
	localparam int EV_COUNT = 5;
endpackage

// ===== hdl/i2c_status_flags.sv
// Overview of operation
// - Reset loads status register with zero
// - Every status register read inserts one wait
// - Master flag set on generated start
// - Master flag cleared by stop, loss, release, disable
// - Arbitration loss sets flag, clears master flag
// - Loss flag clears after read or disable
// - Bit instruction elsewhere also clears loss flag
// - Extension code flag set at eighth clock
// - Address match flag set at eighth clock
// - Code and match flags cleared by conditions
// - Enable falling edge clears four flags
// - Release is control bit 6, enable bit 7
`timescale 1ns/10ps
`default_nettype none

module i2c_status_flags (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        link_clk_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] addr_i,
	output logic             wait_o,
	output logic [7:0]       rd_data_o,
	input  wire logic        bit_instr_i,
	input  wire logic        ctrl_wr_i,
	input  wire logic [7:0]  ctrl_wdata_i,
	input  wire logic        start_gen_i,
	input  wire logic [6:0]  own_slave_address_i,
	input  wire logic [3:0]  low_status_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	input  wire logic        own_sda_i
);
	typedef struct packed {
		logic [1:0]                          scl_sy;
		logic [1:0]                          sda_sy;
		logic                                scl_q;
		logic                                sda_q;
		logic [1:0]                          mst_sy;
		logic [6:0]                          addr_m1;
		logic [6:0]                          addr_m2;
		logic [3:0]                          bit_cnt;
		logic [6:0]                          shift;
		logic                                first_byte;
		logic [i2c_status_pkg::EV_COUNT-1:0] tgl;
	} link_s;

	// Lines restart at their pulled-up idle level, so reset makes no false edge
	localparam link_s LINK_IDLE = '{
		scl_sy:  '1,
		sda_sy:  '1,
		scl_q:   '1,
		sda_q:   '1,
		default: '0
	};

	typedef struct packed {
		logic [i2c_status_pkg::EV_COUNT-1:0] ev_m1;
		logic [i2c_status_pkg::EV_COUNT-1:0] ev_m2;
		logic [i2c_status_pkg::EV_COUNT-1:0] ev_m3;
		logic                                enable;
		logic                                rd_phase;
		logic [7:0]                          rd_data;
		logic                                master_active_flag;
		logic                                arbitration_lost_flag;
		logic                                extension_code_flag;
		logic                                address_match_flag;
	} cpu_s;

	link_s l;
	link_s next_l;
	cpu_s  c;
	cpu_s  next_c;

	logic                                scl;
	logic                                sda;
	logic                                start_c;
	logic                                stop_c;
	logic                                rise_c;
	logic [7:0]                          rx_byte;
	logic [i2c_status_pkg::EV_COUNT-1:0] ev;
	logic                                hit;
	logic                                read_done;
	logic                                disable_c;
	logic                                release_c;
	logic                                clr_master;
	logic                                clr_arb;
	logic                                clr_slave;
	logic [7:0]                          status_word;

	// Link domain: bus sampling, start/stop, bit counting and address decode
	always_comb begin
		next_l = l;
		rx_byte = {l.shift, l.sda_sy[1]};
		next_l.scl_sy = {l.scl_sy[0], scl_i};
		next_l.sda_sy = {l.sda_sy[0], sda_i};
		next_l.scl_q = l.scl_sy[1];
		next_l.sda_q = l.sda_sy[1];
		// Both are quasi-static CPU state, so per-bit synchronisers suffice
		next_l.mst_sy = {l.mst_sy[0], c.master_active_flag};
		next_l.addr_m1 = own_slave_address_i;
		next_l.addr_m2 = l.addr_m1;
		scl = l.scl_sy[1];
		sda = l.sda_sy[1];
		start_c = scl && l.scl_q && l.sda_q && !sda;
		stop_c = scl && l.scl_q && !l.sda_q && sda;
		rise_c = scl && !l.scl_q;
		if (start_c) begin
			next_l.bit_cnt = '0;
			next_l.first_byte = 1'b1;
			next_l.tgl[i2c_status_pkg::EV_START] = !l.tgl[i2c_status_pkg::EV_START];
		end else if (stop_c) begin
			next_l.first_byte = 1'b0;
			next_l.tgl[i2c_status_pkg::EV_STOP] = !l.tgl[i2c_status_pkg::EV_STOP];
		end else if (rise_c) begin
			// Released SDA read back low while master means another master won
			if (l.mst_sy[1] && own_sda_i && !sda) begin
				next_l.tgl[i2c_status_pkg::EV_ARB] = !l.tgl[i2c_status_pkg::EV_ARB];
			end
			if (l.bit_cnt < i2c_status_pkg::BYTE_BITS) begin
				next_l.shift = rx_byte[6:0];
				next_l.bit_cnt = l.bit_cnt + i2c_status_pkg::CNT_ONE;
				if (l.first_byte && l.bit_cnt == i2c_status_pkg::BYTE_BITS
						- i2c_status_pkg::CNT_ONE) begin
					next_l.first_byte = 1'b0;
					if (rx_byte[7:4] == i2c_status_pkg::EXT_CODE_LOW
							|| rx_byte[7:4] == i2c_status_pkg::EXT_CODE_HIGH) begin
						next_l.tgl[i2c_status_pkg::EV_EXT] =
							!l.tgl[i2c_status_pkg::EV_EXT];
					end
					if (rx_byte[7:1] == l.addr_m2) begin
						next_l.tgl[i2c_status_pkg::EV_MATCH] =
							!l.tgl[i2c_status_pkg::EV_MATCH];
					end
				end
			end else begin
				next_l.bit_cnt = '0;
			end
		end
	end

	always_ff @(posedge link_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			l <= LINK_IDLE;
		end else begin
			l <= next_l;
		end
	end

	// CPU domain: event synchronisers, flags and the read port
	always_comb begin
		next_c = c;
		next_c.ev_m1 = l.tgl;
		next_c.ev_m2 = c.ev_m1;
		next_c.ev_m3 = c.ev_m2;
		ev = c.ev_m2 ^ c.ev_m3;
		status_word = '0;
		status_word[i2c_status_pkg::LOW_BITS-1:0] = low_status_i;
		status_word[i2c_status_pkg::MASTER_BIT] = c.master_active_flag;
		status_word[i2c_status_pkg::ARB_BIT] = c.arbitration_lost_flag;
		status_word[i2c_status_pkg::EXT_BIT] = c.extension_code_flag;
		status_word[i2c_status_pkg::MATCH_BIT] = c.address_match_flag;
		hit = rd_i && addr_i == i2c_status_pkg::STATUS_ADDR;
		read_done = hit && c.rd_phase;
		release_c = ctrl_wr_i && ctrl_wdata_i[i2c_status_pkg::REL_BIT];
		disable_c = c.enable && ctrl_wr_i && !ctrl_wdata_i[i2c_status_pkg::ENABLE_BIT];
		if (ctrl_wr_i) begin
			next_c.enable = ctrl_wdata_i[i2c_status_pkg::ENABLE_BIT];
		end
		clr_master = ev[i2c_status_pkg::EV_STOP] || ev[i2c_status_pkg::EV_ARB]
			|| release_c || disable_c;
		clr_arb = read_done || bit_instr_i || disable_c;
		clr_slave = ev[i2c_status_pkg::EV_START] || ev[i2c_status_pkg::EV_STOP]
			|| release_c || disable_c;
		// Clear beats set, so a loss landing on the clearing read is dropped
		if (clr_master) begin
			next_c.master_active_flag = 1'b0;
		end else if (start_gen_i) begin
			next_c.master_active_flag = 1'b1;
		end
		if (clr_arb) begin
			next_c.arbitration_lost_flag = 1'b0;
		end else if (ev[i2c_status_pkg::EV_ARB]) begin
			next_c.arbitration_lost_flag = 1'b1;
		end
		if (clr_slave) begin
			next_c.extension_code_flag = 1'b0;
			next_c.address_match_flag = 1'b0;
		end else begin
			if (ev[i2c_status_pkg::EV_EXT]) begin
				next_c.extension_code_flag = 1'b1;
			end
			if (ev[i2c_status_pkg::EV_MATCH]) begin
				next_c.address_match_flag = 1'b1;
			end
		end
		// Every read is stretched by one wait cycle, data captured meanwhile
		next_c.rd_phase = rd_i && !c.rd_phase;
		if (rd_i && !c.rd_phase) begin
			next_c.rd_data = hit ? status_word : '0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			c <= '0;
		end else begin
			c <= next_c;
		end
	end

	assign wait_o = rd_i && !c.rd_phase;
	assign rd_data_o = c.rd_data;

	a_reset_clear: assert property (@(posedge clk_i) $rose(rst_b_i) |->
		rd_data_o == i2c_status_pkg::STATUS_RESET && status_word[7:4] == 4'h0)
		else $error("status not zero after reset");

	a_read_wait_first: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(rd_i && !wait_o) |-> $past(wait_o) && $past(rd_i))
		else $error("read completed without a wait cycle");

	a_master_start_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(start_gen_i && !clr_master) |=> c.master_active_flag)
		else $error("master flag not set by start");

	a_master_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(ev[i2c_status_pkg::EV_STOP] || release_c || disable_c) |=> !c.master_active_flag)
		else $error("master flag not cleared");

	a_arb_loss_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(ev[i2c_status_pkg::EV_ARB] && !clr_arb) |=>
		c.arbitration_lost_flag && !c.master_active_flag)
		else $error("arbitration loss not recorded");

	a_arb_read_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(hit && !wait_o) |=> !c.arbitration_lost_flag)
		else $error("loss flag survived a status read");

	a_arb_bit_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		bit_instr_i |=> !c.arbitration_lost_flag)
		else $error("loss flag survived a bit instruction");

	a_ext_code_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(ev[i2c_status_pkg::EV_EXT] && !clr_slave) |=> c.extension_code_flag)
		else $error("extension code flag not set");

	a_addr_match_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(ev[i2c_status_pkg::EV_MATCH] && !clr_slave) |=> c.address_match_flag)
		else $error("address match flag not set");

	a_slave_flags_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ev[i2c_status_pkg::EV_START] |=> !c.extension_code_flag && !c.address_match_flag)
		else $error("code or match flag survived a start");

	a_disable_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		disable_c |=> status_word[7:4] == 4'h0 && !c.enable)
		else $error("flags survived interface disable");

	a_flags_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(ev == '0 && !start_gen_i && !ctrl_wr_i && !bit_instr_i && !rd_i) |=>
		$stable(status_word[7:4]))
		else $error("flag changed without an event");

	a_read_capture: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(hit && wait_o) |=> rd_data_o == $past(status_word))
		else $error("read data not captured in the wait cycle");

	a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(rd_i && wait_o && !hit) |=> rd_data_o == 8'h00)
		else $error("unmapped read returned data");

	a_arb_no_master: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(c.arbitration_lost_flag) |-> !c.master_active_flag)
		else $error("master flag set beside a fresh loss");

	a_stop_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ev[i2c_status_pkg::EV_STOP] |=>
		!c.master_active_flag && !c.extension_code_flag && !c.address_match_flag)
		else $error("flag survived a stop");

	a_release_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		release_c |=>
		!c.master_active_flag && !c.extension_code_flag && !c.address_match_flag)
		else $error("flag survived a release write");

	a_bit_range: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		l.bit_cnt <= i2c_status_pkg::BYTE_BITS)
		else $error("link bit counter out of range");

	c_master_start: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		start_gen_i ##1 c.master_active_flag);
	c_arb_loss: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(c.arbitration_lost_flag));
	c_match_read: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		c.address_match_flag && hit ##1 hit);
	c_ext_code: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(c.extension_code_flag));
	c_disable: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		disable_c ##1 !c.enable);
endmodule

`default_nettype wire

// ===== testbench/i2c_bus_model.sv
`timescale 1ns/10ps
`default_nettype none

// Another master on the two-wire bus; released lines read high through the pull-ups
module i2c_bus_model (
	output logic scl_o,
	output logic sda_o
);
	localparam time HALF = 300;

	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// Data changes only while the clock is low, so no stray start or stop appears
	task automatic bit_out(input logic b);
		scl_o = 1'b0;
		#HALF sda_o = b;
		#HALF scl_o = 1'b1;
		#HALF;
	endtask

	task automatic start_cond;
		scl_o = 1'b0;
		#HALF sda_o = 1'b1;
		#HALF scl_o = 1'b1;
		#HALF sda_o = 1'b0;
		#HALF;
	endtask

	task automatic stop_cond;
		scl_o = 1'b0;
		#HALF sda_o = 1'b0;
		#HALF scl_o = 1'b1;
		#HALF sda_o = 1'b1;
		#HALF;
	endtask

	// Most significant bit first, ninth clock left released with no acknowledge
	task automatic send(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_out(1'b1);
	endtask
endmodule

`default_nettype wire

// ===== testbench/i2c_status_flags_test.sv
`timescale 1ns/10ps
`default_nettype none

module i2c_status_flags_test;
	logic        clk_i;
	logic        rst_b_i;
	logic        link_clk_i;
	logic        rd_i;
	logic [15:0] addr_i;
	logic        wait_o;
	logic [7:0]  rd_data_o;
	logic        bit_instr_i;
	logic        ctrl_wr_i;
	logic [7:0]  ctrl_wdata_i;
	logic        start_gen_i;
	logic        own_sda_i;
	logic [6:0]  own_slave_address_i;
	logic [3:0]  low_status_i;
	logic        scl;
	logic        sda;
	logic [7:0]  v;
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	i2c_bus_model bus (.scl_o(scl), .sda_o(sda));

	i2c_status_flags DUT (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk_i), .rd_i(rd_i),
		.addr_i(addr_i), .wait_o(wait_o), .rd_data_o(rd_data_o), .bit_instr_i(bit_instr_i),
		.ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i), .start_gen_i(start_gen_i),
		.own_slave_address_i(own_slave_address_i), .low_status_i(low_status_i),
		.scl_i(scl), .sda_i(sda), .own_sda_i(own_sda_i)
	);

	initial begin
		clk_i = 1'b0;
		// Peripheral clock never stops, so status reads are always allowed
		forever #20 clk_i = ~clk_i;
	end

	initial begin
		link_clk_i = 1'b0;
		#3;
		forever #7.5 link_clk_i = ~link_clk_i;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Byte-wide read: one wait cycle, data taken in the completing cycle
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk_i);
		rd_i = 1'b1;
		addr_i = a;
		#1 check({7'h00, wait_o}, 8'h01);
		@(negedge clk_i);
		check({7'h00, wait_o}, 8'h00);
		d = rd_data_o;
		@(negedge clk_i);
		rd_i = 1'b0;
	endtask

	task automatic expect_status(input logic [7:0] e);
		logic [7:0] d;
		rd(16'hffaa, d);
		check(d, e);
	endtask

	task automatic ctrl(input logic [7:0] w);
		@(negedge clk_i);
		ctrl_wr_i = 1'b1;
		ctrl_wdata_i = w;
		@(negedge clk_i);
		ctrl_wr_i = 1'b0;
	endtask

	task automatic gen_start;
		@(negedge clk_i);
		start_gen_i = 1'b1;
		@(negedge clk_i);
		start_gen_i = 1'b0;
	endtask

	// Bus events cross two synchronisers; this waits well beyond that
	task automatic settle;
		repeat (12) @(negedge clk_i);
	endtask

	// Arbitration lost: our transmitter releases the line while the other master pulls it low
	task automatic lose_arb;
		own_sda_i = 1'b1;
		bus.bit_out(1'b0);
		settle();
		own_sda_i = 1'b0;
	endtask

	task automatic summarize;
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		rst_b_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 16'h0000;
		bit_instr_i = 1'b0;
		ctrl_wr_i = 1'b0;
		ctrl_wdata_i = 8'h00;
		start_gen_i = 1'b0;
		own_sda_i = 1'b0;
		own_slave_address_i = 7'h2a;
		low_status_i = 4'h0;
		repeat (10) @(negedge clk_i);
		rst_b_i = 1'b1;
		expect_status(8'h00);
		ctrl(8'h80);
		gen_start();
		expect_status(8'h80);
		bus.start_cond();
		bus.send(8'h54);
		settle();
		expect_status(8'h90);
		bus.stop_cond();
		settle();
		expect_status(8'h00);
		gen_start();
		bus.start_cond();
		bus.send(8'hf0);
		settle();
		expect_status(8'ha0);
		ctrl(8'hc0);
		expect_status(8'h00);
		bus.start_cond();
		bus.send(8'h0e);
		settle();
		expect_status(8'h20);
		bus.start_cond();
		settle();
		expect_status(8'h00);
		gen_start();
		lose_arb();
		rd(16'hffab, v);
		check(v, 8'h00);
		expect_status(8'h40);
		expect_status(8'h00);
		// Lower nibble comes straight from the neighbouring flag logic
		low_status_i = 4'h5;
		expect_status(8'h05);
		low_status_i = 4'h0;
		// A different own address must not match the same byte
		own_slave_address_i = 7'h2b;
		bus.start_cond();
		bus.send(8'h54);
		settle();
		expect_status(8'h00);
		own_slave_address_i = 7'h2a;
		gen_start();
		lose_arb();
		@(negedge clk_i);
		bit_instr_i = 1'b1;
		@(negedge clk_i);
		bit_instr_i = 1'b0;
		expect_status(8'h00);
		bus.start_cond();
		bus.send(8'h54);
		gen_start();
		lose_arb();
		gen_start();
		ctrl(8'h00);
		expect_status(8'h00);
		// Reset in mid-run with the master flag up
		ctrl(8'h80);
		gen_start();
		@(negedge clk_i);
		rst_b_i = 1'b0;
		repeat (2) @(negedge clk_i);
		rst_b_i = 1'b1;
		expect_status(8'h00);
		summarize();
	end
endmodule

`default_nettype wire
